//--- pmt_pkg.sv
// constants, register map and types for the power mode transition block
// assumes a single 50 MHz clock and a classic wishbone register port
package pmt_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] SYS_CTRL1_OFS  = 8'h00;
  localparam logic [7:0] SYS_CTRL2_OFS  = 8'h04;
  localparam logic [7:0] TIMER_A_OFS    = 8'h08;
  localparam logic [7:0] CLK_GATE1_OFS  = 8'h0C;
  localparam logic [7:0] CLK_GATE2_OFS  = 8'h10;
  localparam logic [7:0] MODE_STAT_OFS  = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS   = 8'h1C;
  localparam logic [7:0] IRQ_EN2_OFS    = 8'h20;

  // field positions
  localparam int STBY_SEL_BIT   = 7;
  localparam int WAIT_SEL_LSB   = 4;
  localparam int LOW_SPD_BIT    = 3;
  localparam int DT_EN_BIT      = 4;
  localparam int MED_SPD_BIT    = 3;
  localparam int TMA_PRE_BIT    = 3;
  localparam int WDT_RUN_BIT    = 0;

  // reset values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] GATE_RST   = 8'hFF;
  localparam logic [1:0] IRQ_RST    = 2'h0;

  // transition state counts
  localparam logic [17:0] OLD_STATES  = 18'h00003; // sleep 2 + internal 1
  localparam logic [17:0] EXC_STATES  = 18'h0000E; // exception handling 14
  localparam logic [2:0]  MED_DIV     = 3'h7;      // medium speed: clock/8
  localparam logic [2:0]  WAIT_SEL_MAX = 3'h4;

  // interrupt status bits
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_FALL_BIT  = 1;

  typedef enum logic [1:0] {MODE_HIGH, MODE_MEDIUM, MODE_SUB} cpu_mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_OLD, ST_WAIT, ST_EXC, ST_SLEEP}
    pmt_state_t;

endpackage

//--- clk_gate_cell.sv
// one peripheral clock enable, changed only at a state boundary
// assumes boundary is a one-cycle pulse while the divided clock is low
`timescale 1ns/1ps
`default_nettype none
module clk_gate_cell
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // control
  input  wire logic runReq,
  input  wire logic boundary,
  // gate enable to the peripheral
  output logic      clkRun
);

  typedef struct packed
  {
    logic run;
  } cell_t;

  cell_t cur;
  cell_t next_cur;

  // follow the request only between clock pulses, so no runt edge escapes
  always_comb
  begin
    next_cur = cur;
    if (boundary)
      next_cur.run = runReq;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      cur <= '{run: 1'b1};
    else
      cur <= next_cur;
  end

  assign clkRun = cur.run;

endmodule
`default_nettype wire

//--- power_mode_transition_clock_gate.sv
// power mode direct transition sequencer and peripheral clock gates
// assumes sleepExec and wakeReq are one-cycle pulses from the cpu core,
// subTick is a level synchronous to ref_clk toggling at the subclock rate
//
// Summary of operation
// - a sleep in medium speed with both low power selects and medium select clear and direct transfer on goes to high speed.
// - between active modes, three states pass at the old rate then fourteen exception states at the new rate.
// - a sleep in subactive with standby, no low speed, no medium, direct transfer and prescaler select goes to high speed.
// - the same sleep with medium select set goes to medium speed.
// - leaving subactive, three states pass in subclock periods, then the selected wait plus fourteen states at the new rate.
// - every transition into or out of subactive passes through watch, freezing external inputs meanwhile.
// - a clock-run bit written 0 stops that module clock.
// - a clock-run bit written 1 restarts that module clock.
// - both clock gate registers reset to all ones.
// - the first gate register holds eight bits for timers a, c, f, g, the adc and three serial ports.
// - the second gate register holds the watchdog clock-run bit.
// - once a direct transfer completes, direct transfer exception handling starts.
// - with the direct transfer interrupt disabled, the sleep enters sleep mode instead.
// - a sleep in high speed with low power selects clear, medium select and direct transfer set goes to medium speed.
`timescale 1ns/1ps
`default_nettype none
module power_mode_transition_clock_gate
#(
  parameter logic [17:0] WAIT_BASE = 18'h02000 // 8192 states at select 0
)
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // cpu core side
  input  wire logic              sleepExec,
  input  wire logic              wakeReq,
  input  wire logic              subTick,
  output pmt_pkg::cpu_mode_t     cpuMode,
  output logic                   cpuHold,
  output logic                   dtIrqStart,
  output logic                   watchPass,
  output logic                   sleepMode,
  output logic                   irq,
  // peripheral clock enables
  output logic                   timer_a_clk_run,
  output logic                   timer_c_clk_run,
  output logic                   timer_f_clk_run,
  output logic                   timer_g_clk_run,
  output logic                   adc_clk_run,
  output logic                   serial1_clk_run,
  output logic                   serial3b_clk_run,
  output logic                   serial3a_clk_run,
  output logic                   watchdog_clk_run
);
  import pmt_pkg::*;

  typedef struct packed
  {
    cpu_mode_t  mode;
    cpu_mode_t  target;
    pmt_state_t st;
    logic       viaWatch;
    logic [17:0] cnt;
    logic [2:0] div;
    logic       subPrev;
    logic [7:0] sysCtrl1;
    logic [7:0] sysCtrl2;
    logic [7:0] timerA;
    logic [7:0] gate1;
    logic [7:0] gate2;
    logic       dtIrqEn;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic       ack;
    logic [31:0] rdat;
    logic       dtIrq;
    logic       hold;
    logic       irqOut;
    logic       watchOut;
    logic       sleepOut;
  } top_t;

  top_t cur;
  top_t next_cur;

  logic        tick;
  logic        wbReq;
  logic        wbWr;
  logic        stbySel;
  logic        lowSel;
  logic        medSel;
  logic        dtEn;
  logic        tmaSel;
  logic        match;
  cpu_mode_t   dest;
  logic [2:0]  waitSel;
  logic [17:0] waitStates;
  logic [8:0]  runReq;
  logic [8:0]  runNow;
  logic [1:0]  setEv;

  // control fields
  assign stbySel = cur.sysCtrl1[STBY_SEL_BIT];
  assign lowSel  = cur.sysCtrl1[LOW_SPD_BIT];
  assign medSel  = cur.sysCtrl2[MED_SPD_BIT];
  assign dtEn    = cur.sysCtrl2[DT_EN_BIT];
  assign tmaSel  = cur.timerA[TMA_PRE_BIT];
  assign waitSel = cur.sysCtrl1[WAIT_SEL_LSB +: 3];
  assign wbReq   = wb_cyc_i && wb_stb_i && !cur.ack;
  assign wbWr    = wbReq && wb_we_i && wb_sel_i[0];

  // wait length doubles per select step; steps above the top clamp
  always_comb
  begin
    if (waitSel > WAIT_SEL_MAX)
      waitStates = WAIT_BASE << WAIT_SEL_MAX;
    else
      waitStates = WAIT_BASE << waitSel;
  end

  // one state boundary at the rate of the mode now running
  always_comb
  begin
    unique case (cur.mode)
      MODE_HIGH:   tick = 1'b1;
      MODE_MEDIUM: tick = (cur.div == MED_DIV);
      MODE_SUB:    tick = subTick && !cur.subPrev;
      default:     tick = 1'b1;
    endcase
  end

  // decode which direct transfer a sleep asks for
  always_comb
  begin
    match = 1'b0;
    dest  = cur.mode;
    unique case (cur.mode)
      MODE_MEDIUM:
      begin
        if (!stbySel && !lowSel && !medSel)
        begin
          match = 1'b1;
          dest  = MODE_HIGH;
        end
        else if (stbySel && lowSel && tmaSel)
        begin
          match = 1'b1;
          dest  = MODE_SUB;
        end
      end
      MODE_HIGH:
      begin
        if (!stbySel && !lowSel && medSel)
        begin
          match = 1'b1;
          dest  = MODE_MEDIUM;
        end
        else if (stbySel && lowSel && tmaSel)
        begin
          match = 1'b1;
          dest  = MODE_SUB;
        end
      end
      MODE_SUB:
      begin
        if (stbySel && !lowSel && tmaSel)
        begin
          match = 1'b1;
          dest  = medSel ? MODE_MEDIUM : MODE_HIGH;
        end
      end
      default:
      begin
        match = 1'b0;
        dest  = MODE_HIGH;
      end
    endcase
  end

  // gate request bits in output order
  assign runReq = {cur.gate2[WDT_RUN_BIT], cur.gate1};

  // sequencer, register file and interrupt state
  always_comb
  begin
    next_cur       = cur;
    setEv          = 2'b00;
    next_cur.dtIrq = 1'b0;
    next_cur.ack   = wbReq;
    next_cur.subPrev = subTick;
    next_cur.div   = (cur.mode == MODE_MEDIUM) ? cur.div + 3'h1 : 3'h0;

    unique case (cur.st)
      ST_IDLE:
      begin
        if (sleepExec && dtEn && match)
        begin
          if (cur.dtIrqEn)
          begin
            next_cur.st     = ST_OLD;
            next_cur.target = dest;
            next_cur.hold   = 1'b1;
            next_cur.cnt    = OLD_STATES;
            next_cur.viaWatch = (dest == MODE_SUB) ||
                                (cur.mode == MODE_SUB);
          end
          else
          begin
            next_cur.st   = ST_SLEEP;
            next_cur.hold = 1'b1;
            setEv[IRQ_FALL_BIT] = 1'b1;
          end
        end
      end
      ST_OLD:
      begin
        // counted at the old rate, subclock when leaving subactive
        if (tick)
        begin
          next_cur.cnt = cur.cnt - 18'h1;
          if (cur.cnt == 18'h1)
          begin
            next_cur.mode = cur.target;
            next_cur.div  = 3'h0;
            if (cur.viaWatch)
            begin
              next_cur.st  = ST_WAIT;
              next_cur.cnt = (cur.mode == MODE_SUB) ? waitStates : 18'h1;
            end
            else
            begin
              next_cur.st    = ST_EXC;
              next_cur.cnt   = EXC_STATES;
              next_cur.dtIrq = 1'b1;
            end
          end
        end
      end
      ST_WAIT:
      begin
        // oscillator wait, new rate; watch holds external inputs
        if (tick)
        begin
          next_cur.cnt = cur.cnt - 18'h1;
          if (cur.cnt == 18'h1)
          begin
            next_cur.st    = ST_EXC;
            next_cur.cnt   = EXC_STATES;
            next_cur.dtIrq = 1'b1;
          end
        end
      end
      ST_EXC:
      begin
        if (tick)
        begin
          next_cur.cnt = cur.cnt - 18'h1;
          if (cur.cnt == 18'h1)
          begin
            next_cur.st   = ST_IDLE;
            next_cur.hold = 1'b0;
            setEv[IRQ_DONE_BIT] = 1'b1;
          end
        end
      end
      ST_SLEEP:
      begin
        // wake leaves the running mode unchanged
        if (wakeReq)
        begin
          next_cur.st   = ST_IDLE;
          next_cur.hold = 1'b0;
        end
      end
      default:
      begin
        next_cur.st   = ST_IDLE;
        next_cur.hold = 1'b0;
      end
    endcase

    // register writes
    if (wbWr)
    begin
      unique case (wb_adr_i)
        SYS_CTRL1_OFS: next_cur.sysCtrl1 = wb_dat_i[7:0];
        SYS_CTRL2_OFS: next_cur.sysCtrl2 = wb_dat_i[7:0];
        TIMER_A_OFS:   next_cur.timerA   = wb_dat_i[7:0];
        CLK_GATE1_OFS: next_cur.gate1    = wb_dat_i[7:0];
        CLK_GATE2_OFS: next_cur.gate2    = wb_dat_i[7:0];
        IRQ_STAT_OFS:
          next_cur.irqStat = cur.irqStat & ~wb_dat_i[1:0];
        IRQ_MASK_OFS:  next_cur.irqMask  = wb_dat_i[1:0];
        IRQ_EN2_OFS:   next_cur.dtIrqEn  = wb_dat_i[0];
        default:       next_cur.rdat     = cur.rdat;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_cur.irqStat = next_cur.irqStat | setEv;
    next_cur.irqOut  = |(next_cur.irqStat & next_cur.irqMask);
    // state flags registered so the pins come straight from flops
    next_cur.watchOut = (next_cur.st == ST_WAIT);
    next_cur.sleepOut = (next_cur.st == ST_SLEEP);

    // read data registered with the ack; unmapped reads give zero
    next_cur.rdat = 32'h0;
    if (wbReq && !wb_we_i)
    begin
      unique case (wb_adr_i)
        SYS_CTRL1_OFS: next_cur.rdat[7:0] = cur.sysCtrl1;
        SYS_CTRL2_OFS: next_cur.rdat[7:0] = cur.sysCtrl2;
        TIMER_A_OFS:   next_cur.rdat[7:0] = cur.timerA;
        CLK_GATE1_OFS: next_cur.rdat[7:0] = cur.gate1;
        CLK_GATE2_OFS: next_cur.rdat[7:0] = cur.gate2;
        MODE_STAT_OFS:
          next_cur.rdat[7:0] = {cur.hold, cur.st, 1'b0, cur.viaWatch,
                                cur.mode};
        IRQ_STAT_OFS:  next_cur.rdat[1:0] = cur.irqStat;
        IRQ_MASK_OFS:  next_cur.rdat[1:0] = cur.irqMask;
        IRQ_EN2_OFS:   next_cur.rdat[0]   = cur.dtIrqEn;
        default:       next_cur.rdat      = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cur          <= '0;
      cur.mode     <= MODE_MEDIUM; // reset enters medium speed
      cur.target   <= MODE_MEDIUM;
      cur.st       <= ST_IDLE;
      cur.sysCtrl1 <= CTRL_RST;
      cur.sysCtrl2 <= CTRL_RST;
      cur.timerA   <= CTRL_RST;
      cur.gate1    <= GATE_RST;
      cur.gate2    <= GATE_RST;
      cur.irqStat  <= IRQ_RST;
      cur.irqMask  <= IRQ_RST;
    end
    else
      cur <= next_cur;
  end

  // one glitch-free gate per peripheral, moved on state boundaries only
  genvar g;
  generate
    for (g = 0; g < 9; g++)
    begin : gate_gen
      clk_gate_cell u_cell
      (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .runReq   (runReq[g]),
        .boundary (tick),
        .clkRun   (runNow[g])
      );
    end
  endgenerate

  // outputs straight from flip-flops
  assign wb_dat_o   = cur.rdat;
  assign wb_ack_o   = cur.ack;
  assign cpuMode    = cur.mode;
  assign cpuHold    = cur.hold;
  assign dtIrqStart = cur.dtIrq;
  assign watchPass  = cur.watchOut;
  assign sleepMode  = cur.sleepOut;
  assign irq        = cur.irqOut;
  assign timer_a_clk_run  = runNow[0];
  assign timer_c_clk_run  = runNow[1];
  assign timer_f_clk_run  = runNow[2];
  assign timer_g_clk_run  = runNow[3];
  assign adc_clk_run      = runNow[4];
  assign serial1_clk_run  = runNow[5];
  assign serial3b_clk_run = runNow[6];
  assign serial3a_clk_run = runNow[7];
  assign watchdog_clk_run = runNow[8];

endmodule
`default_nettype wire

//--- power_mode_transition_clock_gate_props.sv
// checker: bus answer, gate and transition timing at the block's ports
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module power_mode_transition_clock_gate_props
(
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               srst,
  // bus
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [7:0]         wb_adr_i,
  input wire logic [3:0]         wb_sel_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  // core side and two gates
  input wire pmt_pkg::cpu_mode_t cpuMode,
  input wire logic               cpuHold,
  input wire logic               dtIrqStart,
  input wire logic               watchPass,
  input wire logic               timer_a_clk_run,
  input wire logic               watchdog_clk_run
);
  import pmt_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // write acknowledged now, registered at the previous edge
  wire wrNow = wb_ack_o && wb_we_i && wb_sel_i[0];
  // exception states keep the core held for at least eight cycles
  sequence excRun;
    (cpuHold && !dtIrqStart) [*8];
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not answered next cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  gate_reset_a: assert property ($fell(srst) |->
    timer_a_clk_run && watchdog_clk_run) else $error("gate reset");
  gate_stop_a: assert property (wrNow && wb_adr_i == CLK_GATE1_OFS
    && !wb_dat_i[0] |-> ##[0:20] !timer_a_clk_run)
    else $error("timer a clock not stopped");
  wdog_run_a: assert property (wrNow && wb_adr_i == CLK_GATE2_OFS
    && wb_dat_i[WDT_RUN_BIT] |-> ##[0:20] watchdog_clk_run)
    else $error("watchdog clock not restored");
  mode_stable_a: assert property (!cpuHold |=> $stable(cpuMode))
    else $error("mode changed outside a transition");
  exc_hold_a: assert property (dtIrqStart |-> cpuHold ##1 excRun)
    else $error("exception states cut short");
  // subclock rate is not visible here, so subactive exceptions are unbounded
  hold_drop_a: assert property (dtIrqStart && cpuMode != MODE_SUB
    |-> ##[14:112] !cpuHold) else $error("hold outlasts exception states");
  watch_inside_a: assert property (watchPass |-> cpuHold)
    else $error("watch passage outside a transition");
endmodule
bind power_mode_transition_clock_gate
  power_mode_transition_clock_gate_props props (.ref_clk, .srst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .cpuMode, .cpuHold, .dtIrqStart, .watchPass,
    .timer_a_clk_run, .watchdog_clk_run);
`default_nettype wire

//--- cpu_core_model.sv
// cpu core model: sleep and wake pulses, free running subclock level
// assumes its tasks are called from the bench's clocked sequence
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
(
  // clock
  input  wire logic ref_clk,
  // core requests
  output var logic  sleepExec,
  output var logic  wakeReq,
  output var logic  subTick
);
  int div = 0;
  initial
  begin
    sleepExec = 1'b0;
    wakeReq = 1'b0;
    subTick = 1'b0;
  end
  // subclock runs free, five system cycles per half period
  always @(posedge ref_clk)
  begin
    div <= (div == 4) ? 0 : div + 1;
    if (div == 4)
      subTick <= ~subTick;
  end
  // one-cycle pulse, wake when w is set, else sleep
  task automatic pulse(input logic w);
    @(posedge ref_clk);
    if (w)
      wakeReq <= 1'b1;
    else
      sleepExec <= 1'b1;
    @(posedge ref_clk);
    sleepExec <= 1'b0;
    wakeReq <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- power_mode_transition_clock_gate_bench.sv
// bench: registers, peripheral gates and the direct mode transitions
// assumes the core model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module power_mode_transition_clock_gate_bench;
  import pmt_pkg::*;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic        ack, sleepExec, wakeReq, subTick;
  cpu_mode_t   cpuMode;
  logic        cpuHold, dtIrqStart, watchPass, sleepMode, irq;
  logic [8:0]  run;
  logic [15:0] q[$];
  logic [15:0] note;
  logic [31:0] seed = 32'h00012341;
  logic        sawWatch = 1'b0;
  int          fails = 0;
  int          num_checks = 0;
  int          cycN = 0;
  power_mode_transition_clock_gate #(.WAIT_BASE(18'h00004)) dut
  (
    .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sleepExec(sleepExec),
    .wakeReq(wakeReq), .subTick(subTick), .cpuMode(cpuMode),
    .cpuHold(cpuHold), .dtIrqStart(dtIrqStart), .watchPass(watchPass),
    .sleepMode(sleepMode), .irq(irq), .timer_a_clk_run(run[0]),
    .timer_c_clk_run(run[1]), .timer_f_clk_run(run[2]),
    .timer_g_clk_run(run[3]), .adc_clk_run(run[4]),
    .serial1_clk_run(run[5]), .serial3b_clk_run(run[6]),
    .serial3a_clk_run(run[7]), .watchdog_clk_run(run[8])
  );
  cpu_core_model core (.ref_clk(ref_clk), .sleepExec(sleepExec),
    .wakeReq(wakeReq), .subTick(subTick));
  always #10 ref_clk = ~ref_clk;
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // cycle ceiling well above the run, and watch passage seen
  always @(posedge ref_clk)
  begin
    cycN <= cycN + 1;
    if (watchPass === 1'b1)
      sawWatch <= 1'b1;
    if (cycN == 30000)
    begin
      fails++;
      test_done();
    end
  end
  // oldest read note against returned data, upper bits must read 0
  always @(posedge ref_clk)
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0)
    begin
      note = q.pop_front();
      chk("read", rdat & {24'hFFFFFF, note[15:8]}, {24'h0, note[7:0]});
    end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // classic cycle: hold request until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (ack !== 1'b1);
    cyc <= 1'b0;
    we <= 1'b0;
    chk("ack", {31'h0, ack}, 32'h1);
    // taken at the first edge, answered exactly one cycle later
    chk("ack wait", n, 32'h00000002);
  endtask
  task automatic rd(input logic [7:0] a, e, m);
    q.push_back({m, e});
    wb(1'b0, a, 8'h00);
  endtask
  // one direct transfer, waits until the core is released
  task automatic trans(input logic [7:0] c1, c2, input cpu_mode_t m,
    input logic w);
    int n;
    n = 0;
    wb(1'b1, SYS_CTRL1_OFS, c1);
    wb(1'b1, SYS_CTRL2_OFS, c2);
    sawWatch = 1'b0;
    core.pulse(1'b0);
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (cpuHold !== 1'b0 || n < 3);
    chk("mode", {30'h0, cpuMode}, {30'h0, m});
    chk("watch", {31'h0, sawWatch}, {31'h0, w});
    chk("irq", {31'h0, irq}, 32'h1);
    rd(IRQ_STAT_OFS, 8'h01, 8'h01);
    wb(1'b1, IRQ_STAT_OFS, 8'h01);
    rd(MODE_STAT_OFS, {6'h0, m}, 8'h03);
    chk("irq clear", {31'h0, irq}, 32'h0);
    $display("test transition to mode %0d done", m);
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(CLK_GATE1_OFS, 8'hFF, 8'hFF);
    rd(CLK_GATE2_OFS, 8'hFF, 8'hFF);
    rd(MODE_STAT_OFS, 8'h01, 8'h03);
    rd(8'h24, 8'h00, 8'hFF);
    chk("runs", {23'h0, run}, 32'h000001FF);
    $display("test reset done");
    // random patterns: gates move only on a state tick, so allow time
    repeat (3)
    begin
      seed = xs(seed);
      wb(1'b1, CLK_GATE1_OFS, seed[7:0]);
      repeat (20) @(posedge ref_clk);
      chk("gate1", {24'h0, run[7:0]}, {24'h0, seed[7:0]});
      rd(CLK_GATE1_OFS, seed[7:0], 8'hFF);
    end
    wb(1'b1, CLK_GATE2_OFS, 8'h00);
    repeat (20) @(posedge ref_clk);
    chk("wdog off", {31'h0, run[8]}, 32'h0);
    wb(1'b1, CLK_GATE2_OFS, 8'hFF);
    repeat (20) @(posedge ref_clk);
    chk("wdog on", {31'h0, run[8]}, 32'h1);
    $display("test gates done");
    wb(1'b1, TIMER_A_OFS, 8'h08);
    wb(1'b1, IRQ_EN2_OFS, 8'h01);
    wb(1'b1, IRQ_MASK_OFS, 8'h01);
    trans(8'h00, 8'h10, MODE_HIGH, 1'b0);
    trans(8'h00, 8'h18, MODE_MEDIUM, 1'b0);
    trans(8'h88, 8'h10, MODE_SUB, 1'b1);
    trans(8'h90, 8'h10, MODE_HIGH, 1'b1);
    trans(8'h88, 8'h10, MODE_SUB, 1'b1);
    trans(8'hC0, 8'h18, MODE_MEDIUM, 1'b1);
    // interrupt disabled: sleep instead, masked status, then wake
    wb(1'b1, IRQ_EN2_OFS, 8'h00);
    wb(1'b1, SYS_CTRL1_OFS, 8'h00);
    wb(1'b1, SYS_CTRL2_OFS, 8'h10);
    core.pulse(1'b0);
    repeat (4) @(posedge ref_clk);
    chk("fallback", {30'h0, sleepMode, cpuHold}, 32'h3);
    rd(IRQ_STAT_OFS, 8'h02, 8'h02);
    chk("masked", {31'h0, irq}, 32'h0);
    core.pulse(1'b1);
    repeat (4) @(posedge ref_clk);
    chk("woken", {29'h0, cpuHold, cpuMode}, {29'h0, 1'b0, MODE_MEDIUM});
    $display("test fallback done");
    test_done();
  end
endmodule
`default_nettype wire
